// >>> rtl/fdc_host_defs.svh
// Constants for the floppy controller host phase and status block
// Functional notes
// - End-of-cylinder is bit 7; bits 6,3 zero
// - CRC error in ID or data sets bit 5
// - Unserviced byte in time sets overrun bit 4
// - Sector/ID/track-start missing sets no-data bit 2
// - Write-protect during write/format sets bit 1
// - Missing mark sets bit 0, data case too
// - Deleted mark sets control-mark bit 6
// - Data field CRC sets bit 5
// - Cylinder mismatch sets wrong-cylinder bit 4
// - Mismatch with all-ones cylinder sets bit 1
// - Scan equal sets bit 3, unmet bit 2
// - Drive status mirrors live drive signals
// - Programmed-I/O interrupt per byte, strobe clears
// - DMA request per byte, acknowledge clears it
// - Result interrupt at end, cleared first read
// - New command refused until results read
// - Command order fixed, execution starts automatically
// - Main status always; others only in results
// - Interrupt code encoding in primary status
// - Specify bit selects programmed-I/O or DMA
// - Poll ready lines between commands, interrupt change
// - Poll each drive every 1.024 ms
`ifndef FDC_HOST_DEFS_SVH
`define FDC_HOST_DEFS_SVH
`define CLK_MHZ          50
`define POLL_PERIOD_NS   1024000
`define POLL_CYCLES      ((`POLL_PERIOD_NS * `CLK_MHZ) / 1000)
`define MSR_RQM          7
`define MSR_DIO          6
`define MSR_EXEC         5
`define MSR_BUSY         4
`define ERR_EOC          7
`define ERR_CRC          5
`define ERR_OVR          4
`define ERR_NODATA       2
`define ERR_NOWR         1
`define ERR_MISS         0
`define DF_CM            6
`define DF_DD            5
`define DF_WC            4
`define DF_SH            3
`define DF_SN            2
`define DF_BC            1
`define DF_MD            0
`define CYL_ALL_ONES     8'hff
`define IC_NORMAL        2'h0
`define IC_ABNORMAL      2'h1
`define IC_INVALID       2'h2
`define IC_READY_CHG     2'h3
`define RES_CNT_MAX      3'h7
`endif

// >>> rtl/fdc_host_pkg.sv
// Types for the floppy controller host phase and status block
package fdc_host_pkg;
  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_EXEC = 2'b01,
    PH_RES  = 2'b10
  } phase_t;
endpackage : fdc_host_pkg

// >>> rtl/fdc_host_phase.sv
// Host phase sequencing, status registers and drive ready polling
`timescale 1ns/1ps
`include "fdc_host_defs.svh"
module fdc_host_phase #(
  parameter int POLL_CYC = `POLL_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       a0,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] db_in,
  output logic      [7:0] db_out,
  output logic            db_oe,
  input  wire logic       dma_acknowledge_n,
  input  wire logic       terminal_count,
  output logic            dma_request,
  output logic            int_out,
  input  wire logic [2:0] cmd_len,
  input  wire logic [2:0] res_len,
  input  wire logic       cmd_is_rw,
  input  wire logic       exec_byte,
  input  wire logic       exec_done,
  input  wire logic       specify_done,
  input  wire logic       specify_nd,
  input  wire logic [1:0] end_code,
  input  wire logic [7:0] exec_data,
  output logic      [7:0] host_data,
  output logic            host_data_vld,
  input  wire logic       ev_end_cyl,
  input  wire logic       ev_id_crc,
  input  wire logic       ev_data_crc,
  input  wire logic       ev_overrun,
  input  wire logic       ev_no_sector,
  input  wire logic       ev_id_unread,
  input  wire logic       ev_track_start,
  input  wire logic       ev_write_prot,
  input  wire logic       ev_no_id_mark,
  input  wire logic       ev_no_data_mark,
  input  wire logic       ev_deleted_mark,
  input  wire logic       ev_cyl_mismatch,
  input  wire logic [7:0] ev_cyl_read,
  input  wire logic       ev_scan_equal,
  input  wire logic       ev_scan_unmet,
  input  wire logic       drv_fault,
  input  wire logic       drv_wprot,
  input  wire logic       drv_ready,
  input  wire logic       drv_track0,
  input  wire logic       drv_two_side,
  input  wire logic       side_select_state,
  output logic            unit_select_low,
  output logic            unit_select_high,
  output logic [1:0]      phase_out
);
  import fdc_host_pkg::*;

  phase_t      phase_r;
  logic [2:0]  byte_cnt_r;
  logic [7:0]  transfer_error_status_r;
  logic [7:0]  data_field_status_r;
  logic [1:0]  ic_r;
  logic        not_ready_flag_r;
  logic        nd_mode_r;
  logic        poll_en_r;
  logic [1:0]  unit_r;
  logic [3:0]  rdy_seen_r;
  logic [31:0] poll_cnt_r;
  logic        rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3;
  logic        ack_s1, ack_s2, ack_s3, tc_s1, tc_s2;
  logic        cs_s1, cs_s2, a0_s1, a0_s2;
  logic [7:0]  dbi_s1, dbi_s2;
  logic [7:0]  ds_s1, ds_s2;
  logic        rd_fall, wr_rise, ack_fall, sel, data_rd, data_wr;
  logic [7:0]  main_handshake_status, drive_signal_status, primary_result_status;
  logic [7:0]  res_byte;

  // Host pins pass two flops before use
  always_ff @(posedge sys_clk) begin
    rd_s1  <= rd_n;
    rd_s2  <= rd_s1;
    rd_s3  <= rd_s2;
    wr_s1  <= wr_n;
    wr_s2  <= wr_s1;
    wr_s3  <= wr_s2;
    ack_s1 <= dma_acknowledge_n;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
    tc_s1  <= terminal_count;
    tc_s2  <= tc_s1;
    cs_s1  <= cs_n;
    cs_s2  <= cs_s1;
    a0_s1  <= a0;
    a0_s2  <= a0_s1;
    dbi_s1 <= db_in;
    dbi_s2 <= dbi_s1;
    ds_s1  <= {drv_fault, drv_wprot, drv_ready, drv_track0,
               drv_two_side, side_select_state, 2'b00};
    ds_s2  <= ds_s1;
  end

  assign rd_fall  = rd_s3 & ~rd_s2;
  assign wr_rise  = ~wr_s3 & wr_s2;
  assign ack_fall = ack_s3 & ~ack_s2;
  assign sel      = ~cs_s2 | ~ack_s2;
  assign data_rd  = rd_fall & sel & (a0_s2 | ~ack_s2);
  assign data_wr  = wr_rise & sel & (a0_s2 | ~ack_s2);

  assign drive_signal_status = {ds_s2[7:2], unit_r[1], unit_r[0]};
  assign primary_result_status = {ic_r, 2'b00, not_ready_flag_r,
                                  ds_s2[2], unit_r};
  always_comb begin
    main_handshake_status = 8'h00;
    main_handshake_status[`MSR_RQM]  = (phase_r != PH_EXEC) | (nd_mode_r & int_out);
    main_handshake_status[`MSR_DIO]  = (phase_r == PH_RES);
    main_handshake_status[`MSR_EXEC] = (phase_r == PH_EXEC) & nd_mode_r;
    main_handshake_status[`MSR_BUSY] = (phase_r != PH_CMD) | (byte_cnt_r != 3'h0);
  end

  // Result bytes: primary, error, data field, drive status
  always_comb begin
    unique case (byte_cnt_r)
      3'h0:    res_byte = primary_result_status;
      3'h1:    res_byte = transfer_error_status_r;
      3'h2:    res_byte = data_field_status_r;
      3'h3:    res_byte = drive_signal_status;
      default: res_byte = 8'h00;
    endcase
  end

  // Phase sequencing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r    <= PH_CMD;
      byte_cnt_r <= 3'h0;
    end else begin
      unique case (phase_r)
        PH_CMD: if (data_wr) begin
          if (byte_cnt_r + 3'h1 >= cmd_len) begin
            phase_r    <= PH_EXEC;
            byte_cnt_r <= 3'h0;
          end else begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
          end
        end
        PH_EXEC: if (exec_done || tc_s2) begin
          phase_r    <= PH_RES;
          byte_cnt_r <= 3'h0;
        end
        PH_RES: if (data_rd) begin
          if (byte_cnt_r + 3'h1 >= res_len) begin
            phase_r    <= PH_CMD;
            byte_cnt_r <= 3'h0;
          end else begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
          end
        end
        default: phase_r <= PH_CMD;
      endcase
    end
  end

  // Read data path; main status readable at any time
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      db_out <= 8'h00;
      db_oe  <= 1'b0;
    end else begin
      db_oe <= ~rd_s2 & sel;
      if (rd_fall && !cs_s2 && !a0_s2) begin
        db_out <= main_handshake_status;
      end else if (data_rd) begin
        db_out <= (phase_r == PH_RES) ? res_byte : exec_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_data     <= 8'h00;
      host_data_vld <= 1'b0;
    end else begin
      // Only command bytes are taken; later data writes are refused
      host_data_vld <= data_wr && phase_r == PH_CMD;
      if (data_wr && phase_r == PH_CMD) begin
        host_data <= dbi_s2;
      end
    end
  end

  // Interrupt: per byte, result entry, ready change
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_out <= 1'b0;
    end else if (phase_r == PH_EXEC && nd_mode_r && exec_byte) begin
      int_out <= 1'b1;
    end else if (phase_r == PH_EXEC && (exec_done || tc_s2)) begin
      int_out <= 1'b1;
    end else if (poll_en_r && phase_r == PH_CMD && byte_cnt_r == 3'h0 &&
                 poll_cnt_r == 32'h0 &&
                 rdy_seen_r[unit_r] != ds_s2[5]) begin
      int_out <= 1'b1;
    end else if (data_rd || (data_wr && phase_r != PH_RES)) begin
      int_out <= 1'b0;
    end
  end

  // DMA request per byte, acknowledge clears
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dma_request <= 1'b0;
    end else if (phase_r == PH_EXEC && !nd_mode_r && exec_byte) begin
      dma_request <= 1'b1;
    end else if (ack_fall || phase_r != PH_EXEC) begin
      dma_request <= 1'b0;
    end
  end

  // Transfer mode from specify; ND=1 programmed-I/O
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nd_mode_r <= 1'b0;
      poll_en_r <= 1'b0;
    end else if (specify_done) begin
      nd_mode_r <= specify_nd;
      poll_en_r <= 1'b1;
    end
  end

  // Error status; cleared at command start, set wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      transfer_error_status_r <= 8'h00;
    end else begin
      if (phase_r == PH_CMD && data_wr && byte_cnt_r == 3'h0) begin
        transfer_error_status_r <= 8'h00;
      end
      if (phase_r == PH_EXEC) begin
        if (ev_end_cyl) transfer_error_status_r[`ERR_EOC] <= 1'b1;
        if (ev_id_crc || ev_data_crc)
          transfer_error_status_r[`ERR_CRC] <= 1'b1;
        if (ev_overrun) transfer_error_status_r[`ERR_OVR] <= 1'b1;
        if (ev_no_sector || ev_id_unread || ev_track_start)
          transfer_error_status_r[`ERR_NODATA] <= 1'b1;
        if (ev_write_prot) transfer_error_status_r[`ERR_NOWR] <= 1'b1;
        if (ev_no_id_mark || ev_no_data_mark)
          transfer_error_status_r[`ERR_MISS] <= 1'b1;
      end
    end
  end

  // Data field status; bit 7 stays zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_field_status_r <= 8'h00;
    end else begin
      if (phase_r == PH_CMD && data_wr && byte_cnt_r == 3'h0) begin
        data_field_status_r <= 8'h00;
      end
      if (phase_r == PH_EXEC) begin
        if (ev_deleted_mark) data_field_status_r[`DF_CM] <= 1'b1;
        if (ev_data_crc) data_field_status_r[`DF_DD] <= 1'b1;
        if (ev_cyl_mismatch) data_field_status_r[`DF_WC] <= 1'b1;
        if (ev_scan_equal) data_field_status_r[`DF_SH] <= 1'b1;
        if (ev_scan_unmet) data_field_status_r[`DF_SN] <= 1'b1;
        if (ev_cyl_mismatch && ev_cyl_read == `CYL_ALL_ONES)
          data_field_status_r[`DF_BC] <= 1'b1;
        if (ev_no_data_mark) data_field_status_r[`DF_MD] <= 1'b1;
      end
    end
  end

  // Interrupt code and not-ready capture
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ic_r             <= `IC_NORMAL;
      not_ready_flag_r <= 1'b0;
    end else if (phase_r == PH_EXEC && (exec_done || tc_s2)) begin
      ic_r             <= end_code;
      not_ready_flag_r <= ~ds_s2[5];
    end else if (poll_en_r && phase_r == PH_CMD && byte_cnt_r == 3'h0 &&
                 poll_cnt_r == 32'h0 &&
                 rdy_seen_r[unit_r] != ds_s2[5]) begin
      ic_r             <= `IC_READY_CHG;
      not_ready_flag_r <= ~ds_s2[5];
    end
  end

  // Ready polling, one drive per slot; idle during read/write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      poll_cnt_r <= 32'h0;
      unit_r     <= 2'h0;
      rdy_seen_r <= 4'h0;
    end else if (poll_en_r && !(phase_r != PH_CMD && cmd_is_rw)) begin
      if (poll_cnt_r == 32'h0) begin
        poll_cnt_r <= 32'(POLL_CYC / 4 - 1);
        if (phase_r == PH_CMD) begin
          rdy_seen_r[unit_r] <= ds_s2[5];
          unit_r <= unit_r + 2'h1;
        end
      end else begin
        poll_cnt_r <= poll_cnt_r - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unit_select_low  <= 1'b0;
      unit_select_high <= 1'b0;
      phase_out        <= 2'b00;
    end else begin
      unit_select_low  <= unit_r[0];
      unit_select_high <= unit_r[1];
      phase_out        <= phase_r;
    end
  end
endmodule : fdc_host_phase

// >>> testbench/fdc_host_phase_asserts.sv
// Checker on the ports of the host phase block
`timescale 1ns/1ps
module fdc_host_phase_asserts
  import fdc_host_pkg::*;
#(
  parameter int POLL_CYC = 16
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       db_oe,
  input wire logic       dma_acknowledge_n,
  input wire logic       dma_request,
  input wire logic       int_out,
  input wire logic       exec_byte,
  input wire logic       exec_done,
  input wire logic       specify_done,
  input wire logic       specify_nd,
  input wire logic       host_data_vld,
  input wire logic       unit_select_low,
  input wire logic       unit_select_high,
  input wire logic [1:0] phase_out
);
  localparam int SLOT = POLL_CYC / 4;
  logic        nd_r;
  logic [15:0] stay_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      nd_r <= 1'b0;
    else if (specify_done)
      nd_r <= specify_nd;
  end
  // Cycles since the polled unit last moved
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      stay_r <= 16'h0000;
    else if ($changed({unit_select_high, unit_select_low}))
      stay_r <= 16'h0000;
    else if (stay_r != 16'hffff)
      stay_r <= stay_r + 16'h0001;
  end
  sequence s_exec_end;
    phase_out == PH_EXEC && exec_done;
  endsequence
  sequence s_res_int;
    int_out && phase_out == PH_RES;
  endsequence
  chk_reset_idle: assert property (
    $rose(rst_n) |-> !int_out && !dma_request && phase_out == PH_CMD)
    else $error("outputs busy after reset");
  chk_pio_int: assert property (
    nd_r && exec_byte && phase_out == PH_EXEC |=> int_out)
    else $error("no interrupt for byte");
  chk_dma_req: assert property (
    !nd_r && exec_byte && phase_out == PH_EXEC |=> dma_request)
    else $error("no dma request for byte");
  chk_dma_no_int: assert property (
    !nd_r && phase_out == PH_EXEC |-> !int_out or (##1 phase_out == PH_RES))
    else $error("interrupt in dma execution");
  chk_ack_clears: assert property (
    dma_request && $fell(dma_acknowledge_n) |-> ##[1:6] !dma_request)
    else $error("request not cleared by ack");
  chk_end_int: assert property (
    s_exec_end |=> int_out ##1 s_res_int)
    else $error("no result interrupt");
  chk_res_refuse: assert property (
    phase_out == PH_RES |-> !host_data_vld)
    else $error("write taken in result phase");
  chk_poll_slot: assert property (
    $changed({unit_select_high, unit_select_low}) |-> stay_r >= SLOT - 1)
    else $error("poll slot too short");
  chk_oe_read: assert property (
    $fell(rd_n) && !cs_n |-> ##3 db_oe)
    else $error("bus not driven on read");
endmodule : fdc_host_phase_asserts
bind fdc_host_phase fdc_host_phase_asserts #(.POLL_CYC(POLL_CYC)) u_chk (
  .sys_clk, .rst_n, .cs_n, .rd_n, .db_oe, .dma_acknowledge_n,
  .dma_request, .int_out,
  .exec_byte, .exec_done, .specify_done, .specify_nd, .host_data_vld,
  .unit_select_low, .unit_select_high, .phase_out);

// >>> testbench/host_model.sv
// Host processor and DMA controller driving the host pins
`timescale 1ns/1ps
module host_model #(
  parameter int GAP = 600
) (
  input  wire logic       sys_clk,
  input  wire logic [7:0] db_out,
  output logic            cs_n,
  output logic            a0,
  output logic            rd_n,
  output logic            wr_n,
  output logic            dma_acknowledge_n,
  output logic      [7:0] db_in
);
  initial begin
    cs_n = 1'b1;
    a0 = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dma_acknowledge_n = 1'b1;
    db_in = 8'h00;
  end
  // One strobe; released data lines show the inverse of the last byte
  task automatic acc(input logic rd, input logic a, input logic [7:0] w,
                     output logic [7:0] r);
    @(posedge sys_clk) #1;
    cs_n = 1'b0;
    a0 = a;
    db_in = w;
    rd_n = !rd;
    wr_n = rd;
    repeat (6) @(posedge sys_clk);
    r = db_out;
    #1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    cs_n = 1'b1;
    db_in = ~w;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : acc
  task automatic put(input logic [7:0] b, output logic [7:0] st);
    logic [7:0] x;
    acc(1'b1, 1'b0, 8'h00, st);
    if (st[7:6] == 2'b10)
      acc(1'b0, 1'b1, b, x);
    repeat (GAP) @(posedge sys_clk);
    #1;
  endtask : put
  task automatic get(output logic [7:0] st, output logic [7:0] d);
    acc(1'b1, 1'b0, 8'h00, st);
    d = 8'h00;
    if (st[7:6] == 2'b11)
      acc(1'b1, 1'b1, 8'h00, d);
    repeat (GAP) @(posedge sys_clk);
    #1;
  endtask : get
  task automatic dma_acknowledge();
    @(posedge sys_clk) #1;
    dma_acknowledge_n = 1'b0;
    rd_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    dma_acknowledge_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : dma_acknowledge
endmodule : host_model

// >>> testbench/tb.sv
// Self-checking bench for the host phase block
`timescale 1ns/1ps
module tb;
  import fdc_host_pkg::*;
  localparam int POLL = 16;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, a0, rd_n, wr_n, dma_acknowledge_n, db_oe;
  logic        terminal_count = 1'b0, dma_request, int_out;
  logic        cmd_is_rw = 1'b0, exec_byte = 1'b0, exec_done = 1'b0;
  logic        specify_done = 1'b0, specify_nd = 1'b0, host_data_vld;
  logic        drv_fault = 1'b1, drv_wprot = 1'b0, drv_ready = 1'b0;
  logic        drv_track0 = 1'b1, drv_two_side = 1'b0;
  logic        side_select_state = 1'b1, unit_select_low, unit_select_high;
  logic [1:0]  end_code = 2'h0, phase_out;
  logic [2:0]  cmd_len = 3'h3, res_len = 3'h7;
  logic [7:0]  db_in, db_out, exec_data = 8'h00, host_data;
  logic [7:0]  ev_cyl_read = 8'h00;
  logic [13:0] ev = 14'h0000;
  int          err_total = 0, tests_run = 0;
  int          vld_cnt = 0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) vld_cnt += int'(host_data_vld === 1'b1);
  fdc_host_phase #(.POLL_CYC(POLL)) dut (.*,
    .ev_end_cyl(ev[0]), .ev_id_crc(ev[1]), .ev_data_crc(ev[2]),
    .ev_overrun(ev[3]), .ev_no_sector(ev[4]), .ev_id_unread(ev[5]),
    .ev_track_start(ev[6]), .ev_write_prot(ev[7]), .ev_no_id_mark(ev[8]),
    .ev_no_data_mark(ev[9]), .ev_deleted_mark(ev[10]),
    .ev_cyl_mismatch(ev[11]), .ev_scan_equal(ev[12]),
    .ev_scan_unmet(ev[13]));
  host_model u_host (.sys_clk, .db_out, .cs_n, .a0, .rd_n, .wr_n,
    .dma_acknowledge_n, .db_in);
  task automatic chk(input string n, input logic [7:0] got,
                     input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic summarize();
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic t_reset();
    logic [7:0] st;
    tick(5);
    rst_n = 1'b1;
    tick(4);
    chk("int", int_out, 1'b0);
    chk("drq", dma_request, 1'b0);
    u_host.acc(1'b1, 1'b0, 8'h00, st);
    chk("msr", st[7:6], 2'b10);
    chk("oe idle", db_oe, 1'b0);
  endtask : t_reset
  task automatic t_specify(input logic nd);
    specify_nd = nd;
    specify_done = 1'b1;
    tick(1);
    specify_done = 1'b0;
    tick(1);
  endtask : t_specify
  task automatic t_cmd(input logic [13:0] m, input logic [7:0] cyl,
    input logic [1:0] code, input logic [7:0] e1, input logic [7:0] e2,
    input logic tc);
    logic [7:0] st, d;
    logic [1:0] us;
    int i, n;
    n = vld_cnt;
    cmd_is_rw = 1'b1;
    end_code = code;
    ev_cyl_read = cyl;
    for (i = 0; i < 3; i++) begin
      u_host.put(8'h46 + i[7:0], st);
      chk("cmd msr", st[7:6], 2'b10);
      chk("cmd byte", host_data, 8'h46 + i[7:0]);
    end
    chk("exec", phase_out, PH_EXEC);
    us = {unit_select_high, unit_select_low};
    exec_data = 8'ha4 ^ {6'h00, code};
    exec_byte = 1'b1;
    tick(1);
    exec_byte = 1'b0;
    tick(2);
    if (specify_nd) begin
      chk("pio int", int_out, 1'b1);
      u_host.acc(1'b1, 1'b0, 8'h00, st);
      chk("pio rqm", {st[7], st[5]}, 2'b11);
      u_host.acc(1'b1, 1'b1, 8'h00, d);
      chk("pio data", d, exec_data);
      chk("pio clr", int_out, 1'b0);
    end else begin
      chk("drq", dma_request, 1'b1);
      chk("dma int", int_out, 1'b0);
      u_host.dma_acknowledge();
      chk("drq clr", dma_request, 1'b0);
      chk("dma data", db_out, exec_data);
    end
    ev = m;
    tick(1);
    ev = 14'h0000;
    if (tc) begin
      terminal_count = 1'b1;
      tick(4);
    end else begin
      exec_done = 1'b1;
      tick(1);
    end
    terminal_count = 1'b0;
    exec_done = 1'b0;
    for (i = 0; i < 8 && int_out !== 1'b1; i++)
      tick(1);
    chk("end int", int_out, 1'b1);
    chk("poll held", {unit_select_high, unit_select_low}, us);
    u_host.acc(1'b0, 1'b1, 8'h3c, d);
    chk("int kept", int_out, 1'b1);
    chk("refused", host_data, 8'h48);
    chk("writes", 8'(vld_cnt - n), 8'h03);
    for (i = 0; i < 7; i++) begin
      chk("res", phase_out, PH_RES);
      u_host.get(st, d);
      chk("res msr", st[7:6], 2'b11);
      case (i)
        0: begin
          chk("code", d[7:6], code);
          chk("st0", d[5:0], {3'b001, side_select_state, us});
        end
        1: chk("err", d, e1);
        2: chk("fld", d, e2);
        3: begin
          chk("drv", d[7:2], 6'h25);
          chk("drv unit", d[1:0], us);
        end
        default: chk("pad", d, 8'h00);
      endcase
      if (i == 0)
        chk("int clr", int_out, 1'b0);
    end
    chk("idle", phase_out, PH_CMD);
    cmd_is_rw = 1'b0;
  endtask : t_cmd
  task automatic t_poll();
    logic [3:0] seen;
    int i;
    seen = 4'h0;
    for (i = 0; i < 2 * POLL; i++) begin
      seen[{unit_select_high, unit_select_low}] = 1'b1;
      tick(1);
    end
    chk("units", seen, 4'hf);
    drv_ready = 1'b1;
    for (i = 0; i < 4 * POLL && int_out !== 1'b1; i++)
      tick(1);
    chk("ready int", int_out, 1'b1);
  endtask : t_poll
  initial begin
    t_reset();
    t_specify(1'b1);
    t_cmd(14'h3fff, 8'hff, 2'h1, 8'hb7, 8'h7f, 1'b0);
    t_cmd(14'h0822, 8'h12, 2'h2, 8'h24, 8'h10, 1'b0);
    t_cmd(14'h00c4, 8'h12, 2'h3, 8'h26, 8'h20, 1'b0);
    t_specify(1'b0);
    t_cmd(14'h0000, 8'h00, 2'h0, 8'h00, 8'h00, 1'b1);
    t_poll();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
endmodule : tb
